//--- src/rhc_pkg.sv
// package of constants and types for the host command interpreter
// Functional notes
// - identical-data write that ends normally replies with end code 00 only
// - lock command carries a 16-bit page bitmap, high byte pages f..8, low byte 7..0
// - an all-zero lock bitmap changes nothing and returns the present lock state
// - lock reply is end code 00 then 16-bit status, pages b and c read zero
// - protection holds until reset clears the lock state, and protected pages ignore later writes
// - test command echoes its data bytes after end code 00, same order
// - in continuous mode the next read waits for an acknowledge
// - an acknowledge gets no reply frame
// - negative acknowledge resends the previous reply unchanged
// - stop abandons the command, enters sleep and replies with an end code
// - stop turns the antenna carrier off if it is on
// - identical-data write stores the same four bytes into every selected page that is not locked
package rhc_pkg;
  localparam logic [7:0] CMD_WRITE_SAME = 8'h03;
  localparam logic [7:0] CMD_LOCK = 8'h09;
  localparam logic [7:0] CMD_TEST = 8'h10;
  localparam logic [7:0] CMD_ACK = 8'h11;
  localparam logic [7:0] CMD_NACK = 8'h12;
  localparam logic [7:0] CMD_STOP = 8'h13;
  localparam logic [7:0] END_OK = 8'h00;
  localparam logic [7:0] END_ERR_FRAME = 8'h14;
  localparam logic [7:0] END_ERR_PAGE = 8'h15;
  localparam logic [7:0] END_ERR_CMD = 8'h18;
  localparam logic [15:0] LOCK_FORBID_MASK = 16'h1800;
  localparam logic [15:0] LOCK_RESET = 16'h0000;
  localparam int PAGES = 16;
  localparam int PAGE_BYTES = 4;
  localparam int RSP_DEPTH = 64;
  localparam int RSP_AW = 6;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RX = 5'b00010,
    ST_EXEC = 5'b00100,
    ST_TX = 5'b01000,
    ST_WRITE = 5'b10000
  } rhc_state_type;
endpackage

//--- src/rhc_rsp_mem.sv
// response buffer memory with registered read data
`timescale 1ns/1ps
module rhc_rsp_mem #(
  parameter int AW = 6
) (
  input wire logic i_core_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:(1<<AW)-1];
  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    // write-through: the end code written on the exec cycle is the first byte read out
    if (i_we && (i_waddr == i_raddr)) begin
      o_rdata <= i_wdata;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule

//--- src/rhc_tag_mem.sv
// tag page store: sixteen pages of four bytes, lock gating done by the caller
`timescale 1ns/1ps
module rhc_tag_mem (
  input wire logic i_core_clk,
  input wire logic i_we,
  input wire logic [3:0] i_page,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_rpage,
  output logic [31:0] o_rdata
);
  logic [31:0] mem [0:15];
  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem[i_page] <= i_wdata;
    end
    o_rdata <= mem[i_rpage];
  end
endmodule

//--- src/rhc_cmd_top.sv
// host command interpreter: frame decode, lock table, write, echo, resend, stop
`timescale 1ns/1ps
module rhc_cmd_top
  import rhc_pkg::*;
#(
  parameter int AW = rhc_pkg::RSP_AW
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // command byte stream from host, one byte per valid, last marks frame end
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_last,
  input wire logic i_cont_mode,
  // response byte stream to host
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic o_tx_last,
  input wire logic i_tx_ready,
  // antenna and status
  input wire logic i_carrier_req,
  output logic o_carrier_on,
  output logic o_sleep,
  output logic o_read_allow,
  output logic [15:0] o_lock_state,
  // tag read port
  input wire logic [3:0] i_tag_rpage,
  output logic [31:0] o_tag_rdata
);
  import rhc_pkg::*;

  typedef struct packed {
    rhc_state_type st;
    logic [7:0] cmd;
    logic [AW-1:0] rx_cnt;
    logic [AW-1:0] rsp_len;
    logic [AW-1:0] tx_idx;
    logic tx_pend;
    logic [15:0] pages;
    logic [31:0] wdata;
    logic [3:0] wpage;
    logic [15:0] lock;
    logic sleep;
    logic carrier;
    logic read_allow;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_last;
  } rhc_regs_type;

  rhc_regs_type r_ff, nxt_r;
  logic rst_s1_ff, rst_n_ff;
  logic rsp_we;
  logic [AW-1:0] rsp_waddr;
  logic [7:0] rsp_wdata;
  logic [7:0] rsp_rdata;
  logic tag_we;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] v);
    inc = v + {{(AW-1){1'b0}}, 1'b1};
  endfunction

  // reset release through two flip-flops
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  rhc_rsp_mem #(.AW(AW)) u_rsp (
    .i_core_clk(i_core_clk),
    .i_we(rsp_we),
    .i_waddr(rsp_waddr),
    .i_wdata(rsp_wdata),
    .i_raddr(nxt_r.tx_idx),
    .o_rdata(rsp_rdata)
  );

  rhc_tag_mem u_tag (
    .i_core_clk(i_core_clk),
    .i_we(tag_we),
    .i_page(r_ff.wpage),
    .i_wdata(r_ff.wdata),
    .i_rpage(i_tag_rpage),
    .o_rdata(o_tag_rdata)
  );

  always_comb begin
    nxt_r = r_ff;
    rsp_we = 1'b0;
    rsp_waddr = r_ff.rx_cnt;
    rsp_wdata = i_rx_data;
    tag_we = 1'b0;
    nxt_r.tx_valid = 1'b0;
    nxt_r.tx_last = 1'b0;
    if (!r_ff.sleep) begin
      nxt_r.carrier = i_carrier_req;
    end
    case (r_ff.st)
      ST_IDLE: begin
        if (i_rx_valid) begin
          nxt_r.cmd = i_rx_data;
          nxt_r.rx_cnt = {{(AW-1){1'b0}}, 1'b1};
          nxt_r.pages = 16'h0000;
          nxt_r.sleep = 1'b0;
          if (i_rx_last) begin
            nxt_r.st = ST_EXEC;
          end else begin
            nxt_r.st = ST_RX;
          end
        end
      end
      ST_RX: begin
        if (i_rx_valid) begin
          nxt_r.rx_cnt = inc(r_ff.rx_cnt);
          if (r_ff.cmd == CMD_TEST) begin
            rsp_we = 1'b1;
          end
          if (r_ff.rx_cnt == 1 || r_ff.rx_cnt == 2) begin
            nxt_r.pages = {r_ff.pages[7:0], i_rx_data};
          end else if (r_ff.rx_cnt >= 3 && r_ff.rx_cnt <= 6) begin
            nxt_r.wdata = {r_ff.wdata[23:0], i_rx_data};
          end
          if (i_rx_data == CMD_STOP && r_ff.cmd != CMD_TEST) begin
            nxt_r.cmd = CMD_STOP;
          end
          if (i_rx_last) begin
            nxt_r.st = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        nxt_r.tx_idx = '0;
        nxt_r.tx_pend = 1'b1;
        nxt_r.st = ST_TX;
        rsp_waddr = '0;
        rsp_we = 1'b1;
        rsp_wdata = END_OK;
        nxt_r.rsp_len = {{(AW-1){1'b0}}, 1'b1};
        case (r_ff.cmd)
          CMD_TEST: begin
            nxt_r.rsp_len = r_ff.rx_cnt;
          end
          CMD_LOCK: begin
            if (r_ff.rx_cnt != 3) begin
              rsp_wdata = END_ERR_FRAME;
            end else if ((r_ff.pages & LOCK_FORBID_MASK) != 16'h0000) begin
              rsp_wdata = END_ERR_PAGE;
            end else begin
              nxt_r.lock = r_ff.lock | r_ff.pages;
              nxt_r.rsp_len = {{(AW-2){1'b0}}, 2'h3};
              nxt_r.st = ST_WRITE;
            end
          end
          CMD_WRITE_SAME: begin
            if (r_ff.rx_cnt != 7) begin
              rsp_wdata = END_ERR_FRAME;
            end else begin
              nxt_r.wpage = 4'h0;
              nxt_r.st = ST_WRITE;
            end
          end
          CMD_ACK: begin
            nxt_r.read_allow = 1'b1;
            nxt_r.tx_pend = 1'b0;
            nxt_r.st = ST_IDLE;
            nxt_r.rsp_len = r_ff.rsp_len;
            rsp_we = 1'b0;
          end
          CMD_NACK: begin
            // keep the previous length too, so the whole reply goes out again
            nxt_r.rsp_len = r_ff.rsp_len;
            rsp_we = 1'b0;
          end
          CMD_STOP: begin
            nxt_r.sleep = 1'b1;
            nxt_r.carrier = 1'b0;
          end
          default: begin
            rsp_wdata = END_ERR_CMD;
          end
        endcase
        if (i_cont_mode && r_ff.cmd != CMD_ACK && r_ff.cmd != CMD_NACK) begin
          nxt_r.read_allow = 1'b0;
        end
      end
      ST_WRITE: begin
        if (r_ff.cmd == CMD_LOCK) begin
          // status written after the end code, pages b and c masked
          rsp_we = 1'b1;
          rsp_waddr = r_ff.wpage == 4'h0 ? {{(AW-2){1'b0}}, 2'd1} : {{(AW-2){1'b0}}, 2'd2};
          rsp_wdata = r_ff.wpage == 4'h0 ? r_ff.lock[15:8] & ~LOCK_FORBID_MASK[15:8]
                                        : r_ff.lock[7:0];
          nxt_r.wpage = r_ff.wpage + 4'h1;
          if (r_ff.wpage == 4'h1) begin
            nxt_r.wpage = 4'h0;
            nxt_r.st = ST_TX;
          end
        end else begin
          // locked pages keep their contents
          tag_we = r_ff.pages[r_ff.wpage] && !r_ff.lock[r_ff.wpage];
          nxt_r.wpage = r_ff.wpage + 4'h1;
          if (r_ff.wpage == 4'hf) begin
            nxt_r.st = ST_TX;
          end
        end
      end
      ST_TX: begin
        nxt_r.tx_valid = r_ff.tx_valid;
        nxt_r.tx_data = r_ff.tx_data;
        nxt_r.tx_last = r_ff.tx_last;
        if (r_ff.tx_pend && (!r_ff.tx_valid || i_tx_ready)) begin
          nxt_r.tx_valid = 1'b1;
          nxt_r.tx_data = rsp_rdata;
          nxt_r.tx_last = inc(r_ff.tx_idx) == r_ff.rsp_len;
          nxt_r.tx_idx = inc(r_ff.tx_idx);
          if (inc(r_ff.tx_idx) == r_ff.rsp_len) begin
            nxt_r.tx_pend = 1'b0;
          end
        end else if (!r_ff.tx_pend && r_ff.tx_valid && i_tx_ready) begin
          nxt_r.tx_valid = 1'b0;
          nxt_r.tx_last = 1'b0;
          nxt_r.st = ST_IDLE;
        end
      end
      default: begin
        nxt_r.st = ST_IDLE;
      end
    endcase
  end

  // register read needs address one cycle early, so tx_idx drives the read port
  always_ff @(posedge i_core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      r_ff <= '{st: ST_IDLE, cmd: 8'h00, rx_cnt: '0, rsp_len: '0, tx_idx: '0, tx_pend: 1'b0,
                pages: 16'h0000, wdata: 32'h0000_0000, wpage: 4'h0, lock: LOCK_RESET,
                sleep: 1'b0, carrier: 1'b0, read_allow: 1'b1,
                tx_valid: 1'b0, tx_data: 8'h00, tx_last: 1'b0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign o_tx_valid = r_ff.tx_valid;
  assign o_tx_data = r_ff.tx_data;
  assign o_tx_last = r_ff.tx_last;
  assign o_carrier_on = r_ff.carrier;
  assign o_sleep = r_ff.sleep;
  assign o_read_allow = r_ff.read_allow;
  assign o_lock_state = r_ff.lock;
endmodule

//--- sim/rhc_cmd_props.sv
// concurrent checks on the command interpreter ports
`timescale 1ns/1ps
module rhc_cmd_props
  import rhc_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // command and reply streams
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_last,
  input wire logic i_cont_mode,
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_data,
  input wire logic o_tx_last,
  input wire logic i_tx_ready,
  // status
  input wire logic o_carrier_on,
  input wire logic o_sleep,
  input wire logic o_read_allow,
  input wire logic [15:0] o_lock_state
);
  logic sof_ff;
  logic [7:0] cmd_ff;
  wire logic [7:0] cmd = sof_ff ? i_rx_data : cmd_ff;
  wire logic fend = i_rx_valid && i_rx_last;
  // bytes during execution are not sent by the bench, so no busy tracking here
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sof_ff <= 1'b1;
      cmd_ff <= 8'h00;
    end else if (i_rx_valid) begin
      sof_ff <= i_rx_last;
      cmd_ff <= cmd;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  chk_lock_kept: assert property ((o_lock_state & $past(o_lock_state)) == $past(o_lock_state))
    else $error("lock bit cleared");
  chk_lock_bc: assert property (o_lock_state[12:11] == 2'h0)
    else $error("lock bits b c set");
  chk_tx_held: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("reply byte dropped");
  chk_sleep_carrier: assert property (o_sleep && $past(o_sleep) |-> !o_carrier_on)
    else $error("carrier on in sleep");
  chk_ack_quiet: assert property (fend && sof_ff && i_rx_data == CMD_ACK |=> !o_tx_valid [*8])
    else $error("reply after ack");
  chk_stop_sleep: assert property (fend && sof_ff && i_rx_data == CMD_STOP |-> ##[1:6] o_sleep)
    else $error("no sleep after stop");
  chk_stop_code: assert property (fend && cmd == CMD_STOP |-> ##[1:6] o_tx_valid)
    else $error("no end code after stop");
  chk_test_echo: assert property (fend && cmd == CMD_TEST |-> ##[1:6] o_tx_valid && o_tx_data == END_OK)
    else $error("test reply not ok");
  chk_cont_hold: assert property (o_tx_valid && i_tx_ready && o_tx_last && i_cont_mode |-> ##[1:2] !o_read_allow)
    else $error("read allowed before ack");
endmodule
bind rhc_cmd_top rhc_cmd_props rhc_cmd_props_inst (.i_core_clk, .i_rst_n, .i_rx_valid, .i_rx_data, .i_rx_last,
  .i_cont_mode, .o_tx_valid, .o_tx_data, .o_tx_last, .i_tx_ready, .o_carrier_on, .o_sleep, .o_read_allow,
  .o_lock_state);

//--- sim/rhc_host_model.sv
// host side model: takes reply bytes, promptly or with stalls
`timescale 1ns/1ps
module rhc_host_model (
  input wire logic i_core_clk,
  input wire logic i_slow,
  input wire logic i_valid,
  input wire logic [7:0] i_data,
  input wire logic i_last,
  output logic o_ready
);
  logic [7:0] got[$];
  int last_pos;
  logic [1:0] cnt;
  initial begin
    o_ready = 1'b0;
    cnt = 2'h0;
    last_pos = 0;
  end
  // slow mode accepts one cycle in four to stress the hold of each byte
  // last_pos equals the count taken only when the final byte carried the last flag
  always @(posedge i_core_clk) begin
    if (o_ready && i_valid) begin
      got.push_back(i_data);
      last_pos = i_last ? got.size() : 0;
    end
    cnt <= cnt + 2'h1;
    o_ready <= !i_slow || (cnt == 2'h3);
  end
endmodule

//--- sim/rfid_host_cmd_lock_ctrl_tb_top.sv
// self-checking bench for the host command interpreter
`timescale 1ns/1ps
module rfid_host_cmd_lock_ctrl_tb_top;
  import rhc_pkg::*;
  logic i_core_clk, i_rst_n, i_rx_valid, i_rx_last, i_cont_mode, i_tx_ready, i_carrier_req, slow;
  logic o_tx_valid, o_tx_last, o_carrier_on, o_sleep, o_read_allow;
  logic [7:0] i_rx_data, o_tx_data;
  logic [3:0] i_tag_rpage;
  logic [15:0] o_lock_state;
  logic [31:0] o_tag_rdata;
  int miscompares = 0;
  int num_checks = 0;
  int fn[9] = '{3, 1, 7, 3, 3, 3, 3, 2, 1};
  int en[9] = '{3, 3, 1, 3, 3, 3, 1, 1, 1};
  logic [55:0] fv[9] = '{56'h10a53c00000000, 56'h12000000000000, 56'h03000611223344, 56'h09000000000000,
    56'h09800200000000, 56'h09000100000000, 56'h09100000000000, 56'h09000000000000, 56'h55000000000000};
  logic [23:0] ev[9] = '{24'h00a53c, 24'h00a53c, 24'h000000, 24'h000000, 24'h008002, 24'h008003, 24'h150000,
    24'h140000, 24'h180000};
  rhc_cmd_top rhc_cmd_top_inst (.i_core_clk, .i_rst_n, .i_rx_valid, .i_rx_data, .i_rx_last, .i_cont_mode,
    .o_tx_valid, .o_tx_data, .o_tx_last, .i_tx_ready, .i_carrier_req, .o_carrier_on, .o_sleep, .o_read_allow,
    .o_lock_state, .i_tag_rpage, .o_tag_rdata);
  rhc_host_model rhc_host_model_inst (.i_core_clk, .i_slow(slow), .i_valid(o_tx_valid), .i_data(o_tx_data),
    .i_last(o_tx_last), .o_ready(i_tx_ready));
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_flag(input string nm, input logic exp, input logic got);
    chk(nm, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic send(input int n, input logic [55:0] f);
    for (int i = 0; i < n; i++) begin
      @(posedge i_core_clk);
      i_rx_valid <= 1'b1;
      i_rx_data <= f[55-8*i -: 8];
      i_rx_last <= (i == n - 1);
    end
    @(posedge i_core_clk);
    i_rx_valid <= 1'b0;
    i_rx_last <= 1'b0;
  endtask
  // the extra cycles after the last byte catch a reply that runs long
  task automatic reply(input int m, input logic [23:0] e);
    repeat (60) begin
      @(negedge i_core_clk);
      if (rhc_host_model_inst.got.size() >= m) break;
    end
    repeat (4) @(negedge i_core_clk);
    chk("reply length", m, rhc_host_model_inst.got.size());
    chk("reply last", m, rhc_host_model_inst.last_pos);
    for (int i = 0; i < m && i < rhc_host_model_inst.got.size(); i++) begin
      chk("reply byte", {24'h0, e[23-8*i -: 8]}, {24'h0, rhc_host_model_inst.got[i]});
    end
    rhc_host_model_inst.got.delete();
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge i_core_clk);
    miscompares++;
    print_verdict();
  end
  initial begin
    {i_rst_n, i_rx_valid, i_rx_last, i_cont_mode, i_carrier_req, slow} = 6'h0;
    i_rx_data = 8'h00;
    i_tag_rpage = 4'h0;
    repeat (4) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    // page c in row six draws the page error end code on purpose
    for (int r = 0; r < 9; r++) begin
      send(fn[r], fv[r]);
      reply(en[r], ev[r]);
      $display("row %0d done", r);
    end
    send(7, 56'h030006deadbeef);
    reply(1, 24'h000000);
    @(posedge i_core_clk);
    i_tag_rpage <= 4'h1;
    repeat (2) @(negedge i_core_clk);
    chk("page one", 32'h11223344, o_tag_rdata);
    @(posedge i_core_clk);
    i_tag_rpage <= 4'h2;
    repeat (2) @(negedge i_core_clk);
    chk("page two", 32'hdeadbeef, o_tag_rdata);
    chk("lock state", 32'h8003, {16'h0, o_lock_state});
    $display("lock write done");
    @(posedge i_core_clk);
    i_carrier_req <= 1'b1;
    repeat (3) @(negedge i_core_clk);
    chk_flag("carrier", 1'b1, o_carrier_on);
    send(1, 56'h13000000000000);
    reply(1, 24'h000000);
    chk_flag("carrier", 1'b0, o_carrier_on);
    chk_flag("sleep", 1'b1, o_sleep);
    $display("stop done");
    @(posedge i_core_clk);
    i_cont_mode <= 1'b1;
    slow <= 1'b1;
    send(3, 56'h10a53c00000000);
    reply(3, 24'h00a53c);
    chk_flag("read allow", 1'b0, o_read_allow);
    send(1, 56'h11000000000000);
    repeat (10) @(negedge i_core_clk);
    chk("ack reply", 0, rhc_host_model_inst.got.size());
    chk_flag("read allow", 1'b1, o_read_allow);
    $display("continuous done");
    @(posedge i_core_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(negedge i_core_clk);
    chk_flag("tx valid", 1'b0, o_tx_valid);
    chk_flag("read allow", 1'b1, o_read_allow);
    chk_flag("carrier", 1'b0, o_carrier_on);
    chk("lock state", 32'h0, {16'h0, o_lock_state});
    @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    send(3, 56'h10a53c00000000);
    reply(3, 24'h00a53c);
    $display("reset done");
    print_verdict();
  end
endmodule
